// file: urt_defs.svh
// Purpose: constants for the ready and holding timing block
// Assumes: 40 MHz clock
// Notes:   counts in clock cycles or 16x ticks
`ifndef URT_DEFS_SVH
`define URT_DEFS_SVH
`define URT_CLK_NS         25
`define URT_DIV_DEFAULT    16'h0016
`define URT_OVERSAMPLE     5'h10
`define URT_STOP_TICK      4'h8
`define URT_TX_MIN_BAUD    8
`define URT_TX_MAX_BAUD    24
`define URT_TX_READY_OUT_MAX_BAUD 16
`define URT_SUB_LAST       4'hF
`define URT_DATA_BITS      4'h8
`define URT_STOP_BIT       4'h9
`endif

// file: urt_pkg.sv
// Purpose: types for the ready and holding timing block
// Assumes: nothing
// Notes:   one-hot states
package urt_pkg;
    typedef enum logic [2:0] {
        URT_RX_IDLE  = 3'b001,
        URT_RX_SHIFT = 3'b010,
        URT_RX_LOAD  = 3'b100
    } urt_rx_state_t;
    typedef enum logic [3:0] {
        URT_TX_IDLE  = 4'b0001,
        URT_TX_WAIT  = 4'b0010,
        URT_TX_START = 4'b0100,
        URT_TX_SHIFT = 4'b1000
    } urt_tx_state_t;
endpackage

// file: urt_ready_timing.sv
// Purpose: ready, interrupt and holding timing of one serial channel
// Assumes: host strobes synchronous to clk, 8N1 framing
// Notes:   holding load lag selectable in non-FIFO mode
//
// Behaviour
// - Receive interrupt within one baud tick of stop
// - Receive ready within one clock of stop
// - Start bit 8 to 24 ticks after clear
// - Transmit ready drops within 16 ticks
// - Baud tick at sixteen times bit rate
// - Non-FIFO holding load lags status one tick when early_load is low
// - FIFO mode data readable with status
`timescale 1ns/1ps
`include "urt_defs.svh"
module urt_ready_timing #(
    parameter int DIV_W = 16
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic [DIV_W-1:0] baud_div,
    input  wire logic             fifo_mode,
    input  wire logic             early_load,
    input  wire logic             rx_line,
    input  wire logic             host_rd,
    input  wire logic             host_wr,
    input  wire logic [7:0]       host_wdata,
    output logic      [7:0]       rx_holding_reg,
    output logic                  rx_avail,
    output logic                  rx_ready_out,
    output logic                  tx_ready_out,
    output logic                  rx_irq,
    output logic                  tx_irq,
    output logic                  tx_line
);
    import urt_pkg::*;

    // Last 16x tick of a bit
    function automatic logic sub_last(input logic [3:0] sub);
        return (sub == `URT_SUB_LAST);
    endfunction

    // ==========================================
    // Baud tick
    logic [DIV_W-1:0] div_cnt;
    logic             tick;
    always_ff @(posedge clk) begin
        if (srst || div_cnt == '0) begin
            div_cnt <= (baud_div == '0) ? '0 : baud_div - DIV_W'(1);
        end else begin
            div_cnt <= div_cnt - DIV_W'(1);
        end
    end
    assign tick = (div_cnt == '0) && !srst;

    // ==========================================
    // Receiver
    urt_rx_state_t rx_state;
    logic [3:0]    rx_sub;
    logic [3:0]    rx_bit;
    logic [7:0]    rx_shift;
    logic          stop_seen;
    assign stop_seen = (rx_state == URT_RX_SHIFT) && tick && sub_last(rx_sub) && rx_bit == `URT_STOP_BIT;
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_state <= URT_RX_IDLE;
            rx_sub   <= 4'h0;
            rx_bit   <= 4'h0;
            rx_shift <= 8'h00;
        end else begin
            unique case (rx_state)
                URT_RX_IDLE: begin
                    rx_sub <= 4'h0;
                    rx_bit <= 4'h0;
                    if (tick && !rx_line) begin
                        rx_state <= URT_RX_SHIFT;
                    end
                end
                URT_RX_SHIFT: begin
                    if (tick) begin
                        rx_sub <= rx_sub + 4'h1;
                        if (rx_sub == `URT_STOP_TICK - 4'h1) begin
                            if (rx_bit >= 4'h1 && rx_bit <= `URT_DATA_BITS) begin
                                rx_shift <= {rx_line, rx_shift[7:1]};
                            end
                        end
                        if (sub_last(rx_sub)) begin
                            rx_bit <= rx_bit + 4'h1;
                            if (rx_bit == `URT_STOP_BIT) begin
                                rx_state <= (fifo_mode || early_load) ? URT_RX_IDLE : URT_RX_LOAD;
                            end
                        end
                    end
                end
                URT_RX_LOAD: begin
                    if (tick) begin
                        rx_state <= URT_RX_IDLE;
                    end
                end
                default: rx_state <= URT_RX_IDLE;
            endcase
        end
    end

    // Holding register load
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_holding_reg <= 8'h00;
        end else if (stop_seen && (fifo_mode || early_load)) begin
            rx_holding_reg <= rx_shift;
        end else if (rx_state == URT_RX_LOAD && tick) begin
            rx_holding_reg <= rx_shift;
        end
    end

    // Status, ready and interrupt; set wins over read
    always_ff @(posedge clk) begin
        if (srst) begin
            rx_avail     <= 1'b0;
            rx_ready_out <= 1'b0;
            rx_irq       <= 1'b0;
        end else if (stop_seen) begin
            rx_avail     <= 1'b1;
            rx_ready_out <= 1'b1;
            rx_irq       <= 1'b1;
        end else if (host_rd) begin
            rx_avail     <= 1'b0;
            rx_ready_out <= 1'b0;
            rx_irq       <= 1'b0;
        end
    end

    // ==========================================
    // Transmitter
    urt_tx_state_t tx_state;
    logic [4:0]    tx_wait;
    logic [3:0]    tx_sub;
    logic [3:0]    tx_bit;
    logic [7:0]    tx_hold;
    logic [7:0]    tx_data;
    logic          tx_pend;
    logic          tx_go;
    logic          tx_bit_end;
    assign tx_go      = (tx_state == URT_TX_WAIT) && tick && tx_wait == 5'(`URT_TX_MIN_BAUD - 1);
    assign tx_bit_end = (tx_state == URT_TX_SHIFT) && tick && sub_last(tx_sub);

    // Holding byte; a write during a frame waits here, last byte wins
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_hold <= 8'h00;
            tx_pend <= 1'b0;
        end else if (host_wr) begin
            tx_hold <= host_wdata;
            tx_pend <= 1'b1;
        end else if (tx_go) begin
            tx_pend <= 1'b0;
        end
    end

    // Frame sequencing; shift byte is frozen at start
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_state <= URT_TX_IDLE;
            tx_wait  <= 5'h00;
            tx_sub   <= 4'h0;
            tx_bit   <= 4'h0;
            tx_data  <= 8'h00;
        end else begin
            unique case (tx_state)
                URT_TX_IDLE: begin
                    if (host_wr || tx_pend) begin
                        tx_state <= URT_TX_WAIT;
                        tx_wait  <= 5'h00;
                    end
                end
                URT_TX_WAIT: begin
                    if (tick) begin
                        tx_wait <= tx_wait + 5'h01;
                    end
                    if (tx_go) begin
                        tx_state <= URT_TX_START;
                        tx_sub   <= 4'h0;
                        tx_bit   <= 4'h0;
                        tx_data  <= tx_hold;
                    end
                end
                URT_TX_START: begin
                    tx_state <= URT_TX_SHIFT;
                end
                URT_TX_SHIFT: begin
                    if (tick) begin
                        tx_sub <= tx_sub + 4'h1;
                    end
                    if (tx_bit_end) begin
                        tx_bit <= tx_bit + 4'h1;
                        if (tx_bit == `URT_STOP_BIT) begin
                            tx_state <= URT_TX_IDLE;
                        end
                    end
                end
                default: tx_state <= URT_TX_IDLE;
            endcase
        end
    end

    // Serial output: start, eight data bits LSB first, stop
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_line <= 1'b1;
        end else if (tx_go) begin
            tx_line <= 1'b0;
        end else if (tx_bit_end && tx_bit < `URT_DATA_BITS) begin
            tx_line <= tx_data[tx_bit[2:0]];
        end else if (tx_bit_end) begin
            tx_line <= 1'b1;
        end
    end

    // Ready drops one clock after start, returns as stop begins
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_ready_out <= 1'b1;
        end else if (tx_state == URT_TX_START) begin
            tx_ready_out <= 1'b0;
        end else if (tx_bit_end && tx_bit == `URT_DATA_BITS) begin
            tx_ready_out <= 1'b1;
        end
    end

    // Holding empty interrupt; set wins over a write in the same cycle
    always_ff @(posedge clk) begin
        if (srst) begin
            tx_irq <= 1'b1;
        end else if (tx_bit_end && tx_bit == `URT_DATA_BITS) begin
            tx_irq <= 1'b1;
        end else if (host_wr) begin
            tx_irq <= 1'b0;
        end
    end
endmodule

// file: urt_ready_checker.sv
// Purpose: port timing checks
// Assumes: baud_div of 2, so one bit is 32 clocks
// Notes:   none
`timescale 1ns/1ps
module urt_ready_checker (
    input wire logic clk,
    input wire logic srst,
    input wire logic host_rd,
    input wire logic host_wr,
    input wire logic rx_avail,
    input wire logic rx_ready_out,
    input wire logic rx_irq,
    input wire logic tx_ready_out,
    input wire logic tx_irq,
    input wire logic tx_line
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_rx_flags_rise: assert property ($rose(rx_avail) |-> rx_ready_out && rx_irq) else $error("rx flags split");
    a_rx_flags_hold: assert property (rx_avail && !host_rd |=> rx_avail && rx_ready_out) else $error("rx lost");
    a_rx_read_clear: assert property (host_rd && rx_avail |=> !rx_ready_out && !rx_irq) else $error("no clear");
    a_wr_irq_clear: assert property (host_wr |=> !tx_irq) else $error("tx irq kept");
    a_tx_start_min: assert property (host_wr && tx_ready_out |=> tx_line [*8]) else $error("start early");
    a_tx_start_max: assert property (host_wr && tx_ready_out |-> ##[1:60] !tx_line) else $error("start late");
    a_tx_ready_drop: assert property ($fell(tx_line) && tx_ready_out |=> !tx_ready_out) else $error("ready kept");
    a_tx_ready_back: assert property ($rose(tx_ready_out) |-> tx_line && tx_irq) else $error("bad free");
endmodule
bind urt_ready_timing urt_ready_checker u_urt_ready_checker (.clk(clk), .srst(srst), .host_rd(host_rd),
    .host_wr(host_wr), .rx_avail(rx_avail), .rx_ready_out(rx_ready_out), .rx_irq(rx_irq),
    .tx_ready_out(tx_ready_out), .tx_irq(tx_irq), .tx_line(tx_line));

// file: urt_line_src.sv
// Purpose: far side serial sender
// Assumes: 32 clocks per bit
// Notes:   8N1, LSB first
`timescale 1ns/1ps
module urt_line_src (
    input wire logic       clk,
    input wire logic       go,
    input wire logic [7:0] data,
    output logic           rx_line
);
    logic [9:0] frame;
    initial rx_line = 1'b1;
    always @(posedge clk) begin
        if (go) begin
            frame = {1'b1, data, 1'b0};
            for (int i = 0; i < 10; i++) begin
                rx_line <= frame[i];
                repeat (32) @(posedge clk);
            end
        end
    end
endmodule

// file: tb_top.sv
// Purpose: self-checking bench
// Assumes: baud_div of 2
// Notes:   none
`timescale 1ns/1ps
module tb_top;
    logic clk = 0, srst = 1, fifo_mode = 0, early_load = 0, host_rd = 0, host_wr = 0, go = 0;
    logic [15:0] baud_div = 16'h0002;
    logic [7:0] host_wdata = 8'h00, src_data = 8'h00, rx_holding_reg;
    logic rx_line, rx_avail, rx_ready_out, tx_ready_out, rx_irq, tx_irq, tx_line;
    int errors = 0, checks_done = 0, n;
    always #12.5 clk = ~clk;
    urt_ready_timing u_urt_ready_timing (.clk(clk), .srst(srst), .baud_div(baud_div), .fifo_mode(fifo_mode),
        .early_load(early_load), .rx_line(rx_line), .host_rd(host_rd), .host_wr(host_wr),
        .host_wdata(host_wdata), .rx_holding_reg(rx_holding_reg), .rx_avail(rx_avail),
        .rx_ready_out(rx_ready_out), .tx_ready_out(tx_ready_out), .rx_irq(rx_irq), .tx_irq(tx_irq),
        .tx_line(tx_line));
    urt_line_src u_urt_line_src (.clk(clk), .go(go), .data(src_data), .rx_line(rx_line));
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task final_report;
        $display("errors %0d checks %0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task t_rx(input logic fm, input logic el, input logic [7:0] b);
        @(posedge clk);
        fifo_mode <= fm; early_load <= el; src_data <= b; go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        n = 0;
        while (rx_avail !== 1'b1 && n < 400) begin @(posedge clk); #1; n++; end
        if (n >= 400) begin errors++; final_report(); end
        chk(n inside {[316:330]}, 1'b1);
        chk(rx_ready_out, 1'b1);
        chk(rx_irq, 1'b1);
        if (fm || el) chk(rx_holding_reg, b);
        else begin
            chk(rx_holding_reg == b, 1'b0);
            repeat (2) @(posedge clk);
            #1 chk(rx_holding_reg, b);
        end
        @(posedge clk); host_rd <= 1'b1;
        @(posedge clk); host_rd <= 1'b0;
        #1 chk(rx_ready_out, 1'b0);
        chk(rx_irq, 1'b0);
    endtask
    task t_tx(input logic [7:0] b);
        @(posedge clk);
        host_wdata <= b; host_wr <= 1'b1;
        @(posedge clk);
        host_wr <= 1'b0;
        n = 0;
        while (tx_line !== 1'b0 && n < 100) begin @(posedge clk); #1; n++; end
        if (n >= 100) begin errors++; final_report(); end
        chk(n inside {[15:49]}, 1'b1);
        chk(tx_irq, 1'b0);
        @(posedge clk); #1 chk(tx_ready_out, 1'b0);
        repeat (15) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (32) @(posedge clk);
            #1 chk(tx_line, b[i]);
        end
        n = 0;
        while (tx_ready_out !== 1'b1 && n < 100) begin @(posedge clk); #1; n++; end
        if (n >= 100) begin errors++; final_report(); end
        chk(tx_irq, 1'b1);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        srst <= 1'b0;
        t_rx(1'b0, 1'b0, 8'hA5);
        t_rx(1'b0, 1'b1, 8'h3C);
        t_rx(1'b1, 1'b0, 8'h81);
        t_tx(8'h96);
        t_tx(8'h01);
        final_report();
    end
endmodule
